// *** hdl/ctw_pkg.sv ***
package ctw_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTW_ADDR_CTRL = 8'h00;
	localparam logic [7:0] CTW_ADDR_STATUS = 8'h04;
	localparam logic [7:0] CTW_ADDR_WAKE = 8'h08;
	localparam logic [7:0] CTW_ADDR_CFG = 8'h0C;
	// ----------------------------------------------------------------
	// Transceiver mode codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CTW_MODE_OFF = 2'h0;
	localparam logic [1:0] CTW_MODE_WAKE = 2'h1;
	localparam logic [1:0] CTW_MODE_NORMAL = 2'h2;
	localparam logic [1:0] CTW_MODE_RXONLY = 2'h3;
	localparam logic [1:0] CTW_MODE_RESET = CTW_MODE_OFF;
	// ----------------------------------------------------------------
	// Chip operating modes
	// ----------------------------------------------------------------
	localparam logic [2:0] CTW_CHIP_NORMAL = 3'h0;
	localparam logic [2:0] CTW_CHIP_STOP = 3'h1;
	localparam logic [2:0] CTW_CHIP_SLEEP = 3'h2;
	localparam logic [2:0] CTW_CHIP_RESTART = 3'h3;
	localparam logic [2:0] CTW_CHIP_FAILSAFE = 3'h4;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTW_ST_FAULT = 0;
	localparam int CTW_ST_UV = 1;
	localparam int CTW_ST_TXTO = 2;
	localparam int CTW_ST_ARMED = 3;
	localparam int CTW_ST_TERM = 4;
	localparam int CTW_ST_TXEN = 5;
	localparam int CTW_WK_BUS = 0;
	localparam int CTW_CFG_WDBUS = 0;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CTW_CLK_MHZ = 25;
	localparam int CTW_WAKE_MIN_NS = 500;
	localparam int CTW_WAKE_MAX_NS = 1800;
	localparam int CTW_TXTO_US = 2700;
	localparam int CTW_BUSTO_US = 5000;
	localparam int CTW_SILENCE_US = 1000;
	localparam int CTW_ENABLE_US = 200;
	localparam int CTW_WAKE_MIN_CYC =
		(CTW_WAKE_MIN_NS * CTW_CLK_MHZ + 999) / 1000;
	localparam int CTW_WAKE_MAX_CYC = CTW_WAKE_MAX_NS * CTW_CLK_MHZ / 1000;
	localparam int CTW_TXTO_CYC = CTW_TXTO_US * CTW_CLK_MHZ;
	localparam int CTW_BUSTO_CYC = CTW_BUSTO_US * CTW_CLK_MHZ;
	localparam int CTW_SILENCE_CYC = CTW_SILENCE_US * CTW_CLK_MHZ;
	localparam int CTW_ENABLE_CYC = CTW_ENABLE_US * CTW_CLK_MHZ;
endpackage

// *** hdl/ctw_mode_wake.sv ***
`timescale 1ns/100ps
module ctw_mode_wake
	import ctw_pkg::*;
#(
	parameter int TXTO_CYC = CTW_TXTO_CYC,
	parameter int BUSTO_CYC = CTW_BUSTO_CYC,
	parameter int SILENCE_CYC = CTW_SILENCE_CYC,
	parameter int ENABLE_CYC = CTW_ENABLE_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] chip_mode,
	input wire logic tx_data_in,
	input wire logic bus_rx,
	input wire logic supply_low,
	output logic rx_data_out,
	output logic bus_tx,
	output logic irq_out_low,
	output logic gnd_term_en,
	output logic watchdog_enable,
	output logic chip_to_restart,
	output logic chip_to_normal
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] chip_prev;
		logic armed;
		logic woken;
		logic wake_flag;
		logic wd_cfg;
		logic fault;
		logic uv_flag;
		logic tx_to;
		logic [1:0] wk_ph;
		logic [31:0] wk_cnt;
		logic [31:0] tx_cnt;
		logic [31:0] bus_cnt;
		logic [31:0] sil_cnt;
		logic [31:0] en_cnt;
		logic tx_gate;
		logic prev_tx;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rx_out;
		logic bus_tx;
		logic irq_n;
		logic term;
		logic wd_en;
		logic to_restart;
		logic to_normal;
	} ctw_state_t;

	ctw_state_t cur;
	ctw_state_t next_s;
	logic wake_hit;
	logic wr;
	logic rd;
	logic fault_set;

	// Every check below runs on the bus clock and rests during reset.
	default clocking dflt_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_s = cur;
		wake_hit = 1'b0;
		fault_set = 1'b0;
		wr = psel && penable && pwrite && !cur.pready;
		rd = psel && penable && !pwrite && !cur.pready;
		next_s.pready = psel && penable && !cur.pready;
		next_s.pslverr = 1'b0;
		next_s.to_restart = 1'b0;
		next_s.to_normal = 1'b0;
		next_s.chip_prev = chip_mode;
		// Chip-level rearm and forced Wake Capable.
		if (chip_mode != cur.chip_prev &&
			(chip_mode == CTW_CHIP_STOP || chip_mode == CTW_CHIP_SLEEP ||
			chip_mode == CTW_CHIP_FAILSAFE)) begin
			next_s.armed = 1'b1;
			next_s.woken = 1'b0;
		end
		if (chip_mode == CTW_CHIP_FAILSAFE && cur.mode != CTW_MODE_WAKE) begin
			next_s.mode = CTW_MODE_WAKE;
			next_s.armed = 1'b1;
			next_s.woken = 1'b0;
		end
		// Wake pattern detector: dom, rec, dom with bounded phases.
		if (cur.mode == CTW_MODE_WAKE && cur.armed) begin
			next_s.wk_cnt = cur.wk_cnt + 32'h1;
			case (cur.wk_ph)
				2'h0: begin
					if (!bus_rx) begin
						next_s.wk_ph = 2'h1;
						next_s.wk_cnt = 32'h1;
					end
				end
				2'h1, 2'h3: begin
					if (bus_rx || cur.wk_cnt >= 32'(CTW_WAKE_MAX_CYC)) begin
						if (cur.wk_cnt >= 32'(CTW_WAKE_MIN_CYC) &&
							cur.wk_cnt < 32'(CTW_WAKE_MAX_CYC)) begin
							if (cur.wk_ph == 2'h3) begin
								wake_hit = 1'b1;
								next_s.wk_ph = 2'h0;
							end else begin
								next_s.wk_ph = 2'h2;
							end
						end else begin
							next_s.wk_ph = 2'h0;
						end
						next_s.wk_cnt = 32'h1;
					end
				end
				default: begin
					if (!bus_rx || cur.wk_cnt >= 32'(CTW_WAKE_MAX_CYC)) begin
						if (!bus_rx && cur.wk_cnt > 32'(CTW_WAKE_MIN_CYC) &&
							cur.wk_cnt < 32'(CTW_WAKE_MAX_CYC)) begin
							next_s.wk_ph = 2'h3;
						end else begin
							next_s.wk_ph = 2'h0;
						end
						next_s.wk_cnt = 32'h1;
					end
				end
			endcase
		end else begin
			next_s.wk_ph = 2'h0;
			next_s.wk_cnt = 32'h0;
		end
		if (wake_hit) begin
			next_s.armed = 1'b0;
			next_s.woken = 1'b1;
			next_s.wake_flag = 1'b1;
			case (chip_mode)
				CTW_CHIP_STOP: begin
					if (cur.wd_cfg) begin
						next_s.wd_en = 1'b1;
					end
				end
				CTW_CHIP_SLEEP: begin
					next_s.to_restart = 1'b1;
					next_s.to_normal = 1'b1;
				end
				CTW_CHIP_RESTART, CTW_CHIP_FAILSAFE: begin
					next_s.to_restart = 1'b1;
				end
				default: begin
				end
			endcase
			if (chip_mode == CTW_CHIP_STOP || chip_mode == CTW_CHIP_NORMAL) begin
				next_s.irq_n = 1'b0;
			end
		end
		// Transmit dominant time-out.
		if (cur.mode == CTW_MODE_NORMAL && !tx_data_in) begin
			if (cur.tx_cnt < 32'(TXTO_CYC)) begin
				next_s.tx_cnt = cur.tx_cnt + 32'h1;
			end else begin
				next_s.tx_to = 1'b1;
				fault_set = 1'b1;
			end
		end else begin
			next_s.tx_cnt = 32'h0;
			next_s.tx_to = 1'b0;
		end
		// Bus dominant clamping, filter longer than transmit time-out.
		if (cur.mode[1] && !bus_rx) begin
			if (cur.bus_cnt < 32'(BUSTO_CYC)) begin
				next_s.bus_cnt = cur.bus_cnt + 32'h1;
			end else begin
				fault_set = 1'b1;
			end
		end else begin
			next_s.bus_cnt = 32'h0;
		end
		next_s.fault = cur.fault | fault_set;
		// Undervoltage only watched with the upper mode bit set.
		if (cur.mode[1] && supply_low) begin
			next_s.uv_flag = 1'b1;
		end
		// Ground termination after bus silence.
		if (cur.mode == CTW_MODE_WAKE && !cur.woken && bus_rx) begin
			if (cur.sil_cnt < 32'(SILENCE_CYC)) begin
				next_s.sil_cnt = cur.sil_cnt + 32'h1;
			end
		end else if (cur.mode != CTW_MODE_WAKE || cur.woken) begin
			next_s.sil_cnt = 32'h0;
		end else begin
			next_s.sil_cnt = cur.sil_cnt;
		end
		next_s.term = cur.mode == CTW_MODE_WAKE && !cur.woken &&
			cur.sil_cnt >= 32'(SILENCE_CYC);
		// Enabling time and dominant-edge gating.
		next_s.prev_tx = tx_data_in;
		if (cur.mode != CTW_MODE_NORMAL) begin
			next_s.en_cnt = 32'h0;
			next_s.tx_gate = 1'b0;
		end else if (cur.en_cnt < 32'(ENABLE_CYC)) begin
			next_s.en_cnt = cur.en_cnt + 32'h1;
		end else if (cur.prev_tx && !tx_data_in) begin
			next_s.tx_gate = 1'b1;
		end
		// The gate's next value lets the first accepted bit out in full.
		next_s.bus_tx = !(cur.mode == CTW_MODE_NORMAL && next_s.tx_gate &&
			!tx_data_in && !cur.tx_to && !supply_low);
		next_s.rx_out = cur.woken ? 1'b0 :
			(cur.mode[1] ? bus_rx : 1'b1);
		// APB register access; hardware sets win over clears.
		if (wr) begin
			if (paddr == CTW_ADDR_CTRL) begin
				if (pwdata[1:0] == CTW_MODE_RXONLY) begin
					if (chip_mode == CTW_CHIP_NORMAL ||
						chip_mode == CTW_CHIP_STOP) begin
						next_s.mode = CTW_MODE_RXONLY;
						next_s.woken = 1'b0;
						next_s.armed = 1'b0;
					end
				end else if (pwdata[1:0] == CTW_MODE_WAKE) begin
					if (chip_mode != CTW_CHIP_FAILSAFE &&
						cur.mode != CTW_MODE_WAKE) begin
						next_s.mode = CTW_MODE_WAKE;
						next_s.armed = 1'b1;
						next_s.woken = 1'b0;
					end
				end else if (chip_mode != CTW_CHIP_FAILSAFE) begin
					next_s.mode = pwdata[1:0];
					next_s.woken = 1'b0;
					next_s.armed = 1'b0;
				end
			end else if (paddr == CTW_ADDR_STATUS) begin
				// A fault raised in this cycle survives the clear.
				next_s.fault = (cur.fault & !pwdata[CTW_ST_FAULT]) |
					fault_set;
				next_s.uv_flag = next_s.uv_flag & !pwdata[CTW_ST_UV] |
					(cur.mode[1] & supply_low);
			end else if (paddr == CTW_ADDR_WAKE) begin
				if (pwdata[CTW_WK_BUS] && !wake_hit) begin
					next_s.wake_flag = 1'b0;
					next_s.irq_n = 1'b1;
				end
			end else if (paddr == CTW_ADDR_CFG) begin
				next_s.wd_cfg = pwdata[CTW_CFG_WDBUS];
				// A watchdog enable from a wake in this cycle wins.
				next_s.wd_en = pwdata[1] | (cur.wd_en & !pwdata[2]) |
					(wake_hit && chip_mode == CTW_CHIP_STOP && cur.wd_cfg);
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		next_s.prdata = 32'h0;
		if (rd) begin
			if (paddr == CTW_ADDR_CTRL) begin
				next_s.prdata[1:0] = cur.mode;
			end else if (paddr == CTW_ADDR_STATUS) begin
				next_s.prdata[CTW_ST_FAULT] = cur.fault;
				next_s.prdata[CTW_ST_UV] = cur.uv_flag;
				next_s.prdata[CTW_ST_TXTO] = cur.tx_to;
				next_s.prdata[CTW_ST_ARMED] = cur.armed;
				next_s.prdata[CTW_ST_TERM] = cur.term;
				next_s.prdata[CTW_ST_TXEN] = cur.tx_gate;
			end else if (paddr == CTW_ADDR_WAKE) begin
				next_s.prdata[CTW_WK_BUS] = cur.wake_flag;
			end else if (paddr == CTW_ADDR_CFG) begin
				next_s.prdata[0] = cur.wd_cfg;
				next_s.prdata[1] = cur.wd_en;
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '0;
			cur.mode <= CTW_MODE_RESET;
			cur.rx_out <= 1'b1;
			cur.bus_tx <= 1'b1;
			cur.irq_n <= 1'b1;
			cur.prev_tx <= 1'b1;
		end else begin
			cur <= next_s;
		end
	end

	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = cur.pslverr;
	assign rx_data_out = cur.rx_out;
	assign bus_tx = cur.bus_tx;
	assign irq_out_low = cur.irq_n;
	assign gnd_term_en = cur.term;
	assign watchdog_enable = cur.wd_en;
	assign chip_to_restart = cur.to_restart;
	assign chip_to_normal = cur.to_normal;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_woken;
		cur.woken ##1 1'b1;
	endsequence
	a_woken_rx_low: assert property (
		s_woken |-> !rx_data_out) else $error("rx not low after wake");
	a_woken_mode: assert property (
		cur.woken |-> cur.mode == CTW_MODE_WAKE) else $error("mode lost");
	a_off_no_wake: assert property (
		cur.mode == CTW_MODE_OFF |=> !$rose(cur.woken)) else $error("wake in off");
	a_failsafe_mode: assert property (
		chip_mode == CTW_CHIP_FAILSAFE |=> cur.mode == CTW_MODE_WAKE)
		else $error("failsafe not wake capable");
	a_txto_recessive: assert property (
		cur.tx_to |=> bus_tx) else $error("tx not recessive");
	a_txto_fault: assert property (
		$rose(cur.tx_to) |-> cur.fault) else $error("fault not set");
	a_rxonly_driver: assert property (
		cur.mode == CTW_MODE_RXONLY |=> bus_tx) else $error("rx only drives");
	a_term_silence: assert property (
		$rose(gnd_term_en) |-> $past(cur.sil_cnt) >= 32'(SILENCE_CYC))
		else $error("term early");
	a_sleep_no_irq: assert property (
		wake_hit && chip_mode == CTW_CHIP_SLEEP && irq_out_low |=> irq_out_low)
		else $error("irq from sleep");
	a_upper_bit: assert property (
		!cur.mode[1] |=> !$rose(cur.uv_flag)) else $error("uv off mode");
	a_sleep_restart: assert property (
		wake_hit && chip_mode == CTW_CHIP_SLEEP |=>
		chip_to_restart && chip_to_normal) else $error("no restart from sleep");
	a_stop_stays: assert property (
		wake_hit && chip_mode == CTW_CHIP_STOP |=> !chip_to_normal)
		else $error("stop left by wake");
	a_wake_irq_low: assert property (
		wake_hit && (chip_mode == CTW_CHIP_STOP ||
		chip_mode == CTW_CHIP_NORMAL) |=> !irq_out_low && cur.wake_flag)
		else $error("wake not signalled");
	a_restart_req: assert property (
		wake_hit && (chip_mode == CTW_CHIP_RESTART ||
		chip_mode == CTW_CHIP_FAILSAFE) |=> chip_to_restart)
		else $error("no restart request");
	a_clamp_fault: assert property (
		cur.mode[1] && !bus_rx && cur.bus_cnt >= 32'(BUSTO_CYC) |=> cur.fault)
		else $error("clamp not flagged");
	a_txto_release: assert property (
		cur.tx_to && tx_data_in |=> !cur.tx_to) else $error("tx not released");
	a_uv_flag_set: assert property (
		cur.mode[1] && supply_low |=> cur.uv_flag) else $error("uv not flagged");
	a_wd_on_wake: assert property (
		wake_hit && chip_mode == CTW_CHIP_STOP && cur.wd_cfg |=> watchdog_enable)
		else $error("watchdog not enabled");
endmodule

// *** tb/ctw_bus_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Bus side partner: wired-AND bus with other nodes
// ----------------------------------------------------------------
module ctw_bus_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bus_tx,
	input wire logic send_wake,
	input wire logic hold_dom,
	output logic bus_rx
);
	logic [6:0] cnt;
	logic pat_dom;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 7'h00;
		end else if (send_wake && cnt == 7'h00) begin
			cnt <= 7'h4B;
		end else if (cnt != 7'h00) begin
			cnt <= cnt - 7'h01;
		end
	end
	// Phases of 25 cycles sit well inside the wake window on both sides.
	assign pat_dom = (cnt > 7'h32) || (cnt != 7'h00 && cnt < 7'h1A);
	assign bus_rx = bus_tx & ~pat_dom & ~hold_dom;
endmodule

// *** tb/ctw_mode_wake_tb.sv ***
`timescale 1ns/100ps
module ctw_mode_wake_tb
	import ctw_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int TXTO = 20;
	localparam int BUSTO = 30;
	localparam int SIL = 10;
	localparam int ENA = 5;
	localparam logic [31:0] M_FT = (32'h1 << CTW_ST_FAULT) |
		(32'h1 << CTW_ST_TXTO);
	localparam logic [31:0] M_F = 32'h1 << CTW_ST_FAULT;
	localparam logic [31:0] M_UV = 32'h1 << CTW_ST_UV;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic supply_low = 0, tx_data_in = 1, send_wake = 0, hold_dom = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic [2:0] chip_mode = CTW_CHIP_NORMAL;
	logic pready, pslverr, bus_rx, rx_data_out, bus_tx, irq_out_low;
	logic gnd_term_en, watchdog_enable, chip_to_restart, chip_to_normal;
	logic rst_seen = 0, nrm_seen = 0, err_seen = 0;
	int errors = 0, cmp_count = 0, ticks = 0;
	always #20 pclk = ~pclk;
	ctw_mode_wake #(.TXTO_CYC(TXTO), .BUSTO_CYC(BUSTO), .SILENCE_CYC(SIL),
		.ENABLE_CYC(ENA)) u_ctw_mode_wake (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chip_mode(chip_mode), .tx_data_in(tx_data_in), .bus_rx(bus_rx),
		.supply_low(supply_low), .rx_data_out(rx_data_out), .bus_tx(bus_tx),
		.irq_out_low(irq_out_low), .gnd_term_en(gnd_term_en),
		.watchdog_enable(watchdog_enable), .chip_to_restart(chip_to_restart),
		.chip_to_normal(chip_to_normal));
	ctw_bus_model u_ctw_bus_model (.pclk(pclk), .presetn(presetn),
		.bus_tx(bus_tx), .send_wake(send_wake), .hold_dom(hold_dom),
		.bus_rx(bus_rx));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic give_verdict();
		if (errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// The request stands until pready is seen high; one idle edge follows.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			$display("mismatch pready expected 1 seen %b", pready);
		end
		q = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, q & m);
	endtask
	task automatic setm(input logic [1:0] m);
		apb(1'b1, CTW_ADDR_CTRL, {30'h0, m});
	endtask
	task automatic wake();
		send_wake <= 1'b1;
		@(posedge pclk);
		send_wake <= 1'b0;
		cyc(90);
	endtask
	always @(posedge pclk) begin
		if (chip_to_restart === 1'b1) rst_seen <= 1'b1;
		if (chip_to_normal === 1'b1) nrm_seen <= 1'b1;
		ticks++;
		if (ticks == 6000) begin
			errors++;
			$display("mismatch run_cycles expected below 6000 seen %0d", ticks);
			give_verdict();
		end
	end
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		cyc(8);
		presetn <= 1'b1;
		@(posedge pclk);
		rdm(CTW_ADDR_CTRL, 32'h3, CTW_MODE_OFF, "reset mode");
		chk("rx idle", 1, rx_data_out);
		wake();
		rdm(CTW_ADDR_WAKE, 32'h1, 32'h0, "wake in off");
		setm(CTW_MODE_WAKE);
		chk("term early", 0, gnd_term_en);
		cyc(SIL + 3);
		chk("term late", 1, gnd_term_en);
		wake();
		chk("rx woken", 0, rx_data_out);
		chk("irq woken", 0, irq_out_low);
		rdm(CTW_ADDR_WAKE, 32'h1, 32'h1, "wake flag");
		rdm(CTW_ADDR_CTRL, 32'h3, CTW_MODE_WAKE, "mode woken");
		apb(1'b1, CTW_ADDR_WAKE, 32'h1);
		setm(CTW_MODE_WAKE);
		wake();
		rdm(CTW_ADDR_WAKE, 32'h1, 32'h0, "no rearm");
		chk("rx held", 0, rx_data_out);
		setm(CTW_MODE_NORMAL);
		cyc(2);
		chk("rx released", 1, rx_data_out);
		setm(CTW_MODE_WAKE);
		wake();
		rdm(CTW_ADDR_WAKE, 32'h1, 32'h1, "rearm toggle");
		apb(1'b1, CTW_ADDR_WAKE, 32'h1);
		apb(1'b1, CTW_ADDR_CFG, 32'h1);
		chk("wd before", 0, watchdog_enable);
		chip_mode <= CTW_CHIP_STOP;
		cyc(3);
		wake();
		chk("wd stop", 1, watchdog_enable);
		chk("stays stop", 0, nrm_seen);
		chk("irq stop", 0, irq_out_low);
		apb(1'b1, CTW_ADDR_WAKE, 32'h1);
		chip_mode <= CTW_CHIP_SLEEP;
		cyc(3);
		wake();
		chk("sleep restart", 1, rst_seen);
		chk("sleep normal", 1, nrm_seen);
		chk("irq sleep", 1, irq_out_low);
		chk("rx sleep", 0, rx_data_out);
		chip_mode <= CTW_CHIP_RESTART;
		setm(CTW_MODE_OFF);
		setm(CTW_MODE_WAKE);
		wake();
		chk("irq restart", 1, irq_out_low);
		chk("rx restart", 0, rx_data_out);
		setm(CTW_MODE_OFF);
		chip_mode <= CTW_CHIP_FAILSAFE;
		cyc(3);
		rdm(CTW_ADDR_CTRL, 32'h3, CTW_MODE_WAKE, "failsafe mode");
		chip_mode <= CTW_CHIP_SLEEP;
		setm(CTW_MODE_RXONLY);
		rdm(CTW_ADDR_CTRL, 32'h3, CTW_MODE_WAKE, "rxonly refused");
		chip_mode <= CTW_CHIP_NORMAL;
		setm(CTW_MODE_NORMAL);
		tx_data_in <= 1'b0;
		cyc(ENA + 3);
		chk("early dominant", 1, bus_tx);
		tx_data_in <= 1'b1;
		cyc(2);
		tx_data_in <= 1'b0;
		cyc(3);
		chk("tx dominant", 0, bus_tx);
		cyc(TXTO + 2);
		chk("tx timeout", 1, bus_tx);
		rdm(CTW_ADDR_STATUS, M_FT, M_FT, "txto flags");
		rdm(CTW_ADDR_CTRL, 32'h3, CTW_MODE_NORMAL, "mode kept");
		tx_data_in <= 1'b1;
		cyc(2);
		tx_data_in <= 1'b0;
		cyc(3);
		chk("tx resumed", 0, bus_tx);
		tx_data_in <= 1'b1;
		apb(1'b1, CTW_ADDR_STATUS, 32'h3);
		setm(CTW_MODE_RXONLY);
		tx_data_in <= 1'b0;
		hold_dom <= 1'b1;
		cyc(3);
		chk("rxonly driver", 1, bus_tx);
		chk("rxonly recv", 0, rx_data_out);
		tx_data_in <= 1'b1;
		cyc(BUSTO + 2);
		rdm(CTW_ADDR_STATUS, M_F, M_F, "clamp fault");
		rdm(CTW_ADDR_CTRL, 32'h3, CTW_MODE_RXONLY, "clamp mode");
		hold_dom <= 1'b0;
		chk("clamp filter", 1, CTW_BUSTO_CYC > CTW_TXTO_CYC);
		apb(1'b1, CTW_ADDR_STATUS, 32'h3);
		setm(CTW_MODE_OFF);
		supply_low <= 1'b1;
		cyc(3);
		rdm(CTW_ADDR_STATUS, M_UV, 32'h0, "uv in off");
		setm(CTW_MODE_NORMAL);
		cyc(ENA + 3);
		rdm(CTW_ADDR_STATUS, M_UV, M_UV, "uv flag");
		tx_data_in <= 1'b0;
		cyc(3);
		chk("uv driver", 1, bus_tx);
		supply_low <= 1'b0;
		cyc(3);
		chk("uv recover", 0, bus_tx);
		tx_data_in <= 1'b1;
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 1, err_seen);
		give_verdict();
	end
endmodule
